// ===== logic/adc_seq_consts.vh
// Register map, field positions, reset values and timing counts of the sequencer
`ifndef ADC_SEQ_CONSTS_VH
`define ADC_SEQ_CONSTS_VH

// Register addresses
`define RA_RES_HIGH    4'h0
`define RA_RES_LOW     4'h1
`define RA_CTRL_CHAN   4'h2
`define RA_CTRL_PORTS  4'h3
`define RA_CTRL_TIMING 4'h4
`define RA_FLAGS       4'h5
`define RA_ENABLES     4'h6
`define RA_PRIORITY    4'h7
`define RA_PIN_LOW     4'h8
`define RA_PIN_HIGH    4'h9

// Field positions
`define F_ON       0
`define F_GO       1
`define F_CHAN_LO  2
`define F_CHAN_HI  5
`define F_PCFG_LO  0
`define F_PCFG_HI  3
`define F_REF_LO   4
`define F_REF_HI   5
`define F_CLK_LO   0
`define F_CLK_HI   2
`define F_ACQ_LO   3
`define F_ACQ_HI   5
`define F_FMT      7
`define F_DONE     6

// Reset values of the port configuration field
`define PCFG_ALL_ANALOG  4'h0
`define PCFG_B_DIGITAL   4'h7

// Compare unit mode that fires the special event trigger
`define CMP_TRIG_MODE 4'hB

// Sequencer timing in conversion bit periods and clocks
`define CONV_TADS    5'd11
`define WAIT_TADS    5'd2
`define INSTR_CLKS   2'd3
`define ACQ_T0 5'd0
`define ACQ_T1 5'd2
`define ACQ_T2 5'd4
`define ACQ_T3 5'd6
`define ACQ_T4 5'd8
`define ACQ_T5 5'd12
`define ACQ_T6 5'd16
`define ACQ_T7 5'd20

// Bit period dividers in system clocks
`define DIV_2  7'd2
`define DIV_4  7'd4
`define DIV_8  7'd8
`define DIV_16 7'd16
`define DIV_32 7'd32
`define DIV_64 7'd64

`endif

// ===== logic/adc_conversion_sequencer.v
// Successive-approximation converter control sequencer with its register file
`timescale 1ns/1ps
`include "adc_seq_consts.vh"

module adc_conversion_sequencer (
    input  wire        clk,              // System clock, 200 MHz
    input  wire        reset,            // Asynchronous reset, active high
    input  wire [3:0]  regAddr,          // Register address
    input  wire [7:0]  regWdata,         // Register write data
    input  wire        regWr,            // Write strobe
    input  wire        regRd,            // Read strobe
    output reg  [7:0]  regRdata,         // Read data, cycle after strobe
    input  wire        portbAnalogReset, // Nonvolatile port B analog select
    input  wire [12:0] pinLevel,         // Digital levels of channel pins
    input  wire        compHighIn,       // Comparator: input above DAC code
    input  wire        rcClkIn,          // Internal RC oscillator
    input  wire        specialTrigger,   // Compare unit two event pulse
    input  wire [3:0]  compareTwoMode,   // Compare unit two mode field
    output wire        timerReset,       // Clears timer one or three
    output wire        sampleEnable,     // Sampling switch closed
    output wire        dischargeEnable,  // Capacitor array discharge
    output wire        convertActive,    // Conversion in progress
    output wire [9:0]  dacCode,          // Trial code for the comparator
    output wire [3:0]  channelSelect,    // Selected analog channel
    output wire [1:0]  referenceConfig,  // Reference selection
    output wire [12:0] analogPinMask     // High where pin is analog
);

    // One-hot sequencer states
    localparam [5:0] S_OFF    = 6'h01;
    localparam [5:0] S_WAIT   = 6'h02;
    localparam [5:0] S_SAMPLE = 6'h04;
    localparam [5:0] S_ACQ    = 6'h08;
    localparam [5:0] S_DELAY  = 6'h10;
    localparam [5:0] S_CONV   = 6'h20;

    reg  [5:0]  state_r;         // Current state
    reg  [5:0]  state_nxt;       // Next state
    reg         on_r;            // Converter on
    reg         go_r;            // Conversion go flag
    reg  [3:0]  chan_r;          // Channel select
    reg  [3:0]  pcfg_r;          // Port configuration field
    reg  [1:0]  ref_r;           // Reference configuration
    reg         fmt_r;           // Result format, 1 = right justified
    reg  [2:0]  acqt_r;          // Acquisition time select
    reg  [2:0]  adcs_r;          // Conversion clock select
    reg         done_r;          // Conversion done flag
    reg         doneEn_r;        // Done interrupt enable bit
    reg         donePri_r;       // Done interrupt priority bit
    reg  [7:0]  resHigh_r;       // Result high byte
    reg  [7:0]  resLow_r;        // Result low byte
    reg         strapDone_r;     // Strap has been taken
    reg  [9:0]  sar_r;           // Approximation register
    reg  [6:0]  divCnt_r;        // Clock divider count
    reg  [4:0]  tadCnt_r;        // Bit periods spent in this state
    reg  [1:0]  delayCnt_r;      // Instruction delay count
    reg         timerReset_r;    // Registered timer clear
    reg  [12:0] pinSync1_r;      // Pin synchroniser first stage
    reg  [12:0] pinSync2_r;      // Pin synchroniser second stage
    reg         compSync1_r;     // Comparator synchroniser first stage
    reg         compSync2_r;     // Comparator synchroniser second stage
    reg         rcSync1_r;       // RC clock synchroniser first stage
    reg         rcSync2_r;       // RC clock synchroniser second stage
    reg         rcPrev_r;        // RC level for edge detection
    reg  [4:0]  acqTads;         // Decoded acquisition length
    reg  [6:0]  divSel;          // Decoded clock divider
    wire [9:0]  sarNext;         // Approximation after this bit period
    wire [12:0] pinRead;         // Pin levels as software sees them
    wire [4:0]  analogCnt;       // Number of analog channels
    wire        rcMode;          // Bit period from the RC oscillator
    wire        tadTick;         // End of a bit period
    wire        phaseChange;     // State changes this cycle
    wire        wrChan;          // Write to channel control
    wire        trigFire;        // Trigger with matching mode
    wire        trigAccept;      // Trigger that sets go
    wire        goSet;           // Go flag set request
    wire        goClr;           // Go flag clear request
    wire        convDone;        // Last bit period of a conversion

    // Output decode straight from flip-flops
    assign sampleEnable    = state_r[2] | state_r[3];
    assign dischargeEnable = state_r[1];
    assign convertActive   = state_r[5];
    assign dacCode         = sar_r;
    assign channelSelect   = chan_r;
    assign referenceConfig = ref_r;
    assign timerReset      = timerReset_r;

    // Trigger qualification
    assign trigFire   = specialTrigger && (compareTwoMode == `CMP_TRIG_MODE);
    assign trigAccept = trigFire && on_r;
    assign wrChan     = regWr && (regAddr == `RA_CTRL_CHAN);

    // Go flag requests; a set in the same cycle as a clear wins
    assign goSet = (wrChan && regWdata[`F_GO] && regWdata[`F_ON]) || trigAccept;
    assign goClr = (wrChan && !regWdata[`F_GO]) || convDone || !on_r;

    // Acquisition length decode
    always @* begin
        case (acqt_r)
            3'd0:    acqTads = `ACQ_T0;
            3'd1:    acqTads = `ACQ_T1;
            3'd2:    acqTads = `ACQ_T2;
            3'd3:    acqTads = `ACQ_T3;
            3'd4:    acqTads = `ACQ_T4;
            3'd5:    acqTads = `ACQ_T5;
            3'd6:    acqTads = `ACQ_T6;
            default: acqTads = `ACQ_T7;
        endcase
    end

    // Divider decode; the two-clock period outruns the comparator synchroniser
    always @* begin
        case (adcs_r)
            3'd0:    divSel = `DIV_2;
            3'd4:    divSel = `DIV_4;
            3'd1:    divSel = `DIV_8;
            3'd5:    divSel = `DIV_16;
            3'd2:    divSel = `DIV_32;
            3'd6:    divSel = `DIV_64;
            default: divSel = `DIV_2;
        endcase
    end

    assign rcMode  = (adcs_r[1:0] == 2'b11);
    assign tadTick = rcMode ? (rcSync2_r & ~rcPrev_r)
                            : (divCnt_r == (divSel - 7'd1));
    assign phaseChange = (state_nxt != state_r);
    assign convDone = state_r[5] && on_r && go_r && tadTick
                      && (tadCnt_r == `CONV_TADS - 5'd1);

    // Next state; channel and direction bits never enter here
    always @* begin
        state_nxt = state_r;
        if (!on_r) begin
            state_nxt = S_OFF;
        end else begin
            case (state_r)
                S_OFF: begin
                    state_nxt = S_WAIT;
                end
                S_WAIT: begin
                    if (tadTick && (tadCnt_r == `WAIT_TADS - 5'd1)) begin
                        state_nxt = S_SAMPLE;
                    end
                end
                S_SAMPLE: begin
                    if (go_r) begin
                        if (acqTads == 5'd0) begin
                            state_nxt = S_DELAY;
                        end else begin
                            state_nxt = S_ACQ;
                        end
                    end
                end
                S_ACQ: begin
                    if (!go_r) begin
                        state_nxt = S_WAIT;
                    end else if (tadTick && (tadCnt_r == acqTads - 5'd1)) begin
                        state_nxt = S_CONV;
                    end
                end
                S_DELAY: begin
                    if (!go_r) begin
                        state_nxt = S_WAIT;
                    end else if (delayCnt_r == `INSTR_CLKS) begin
                        state_nxt = S_CONV;
                    end
                end
                S_CONV: begin
                    if (!go_r) begin
                        state_nxt = S_WAIT;
                    end else if (convDone) begin
                        state_nxt = S_WAIT;
                    end
                end
                default: begin
                    state_nxt = S_OFF;
                end
            endcase
        end
    end

    // State, divider and bit period counters
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r    <= S_OFF;
            divCnt_r   <= 7'h00;
            tadCnt_r   <= 5'h00;
            delayCnt_r <= 2'h0;
        end else begin
            state_r <= state_nxt;
            // Divider restarts with each state so periods start aligned
            if (phaseChange || tadTick) begin
                divCnt_r <= 7'h00;
            end else begin
                divCnt_r <= divCnt_r + 7'd1;
            end
            // Bit periods within the current state
            if (phaseChange) begin
                tadCnt_r <= 5'h00;
            end else if (tadTick) begin
                tadCnt_r <= tadCnt_r + 5'd1;
            end
            // One instruction (four clocks) before a manual start
            if (phaseChange) begin
                delayCnt_r <= 2'h0;
            end else if (state_r[4]) begin
                delayCnt_r <= delayCnt_r + 2'd1;
            end
        end
    end

    // Per-bit trial: decide this bit, arm the next lower one
    genvar i;
    generate
        for (i = 0; i < 10; i = i + 1) begin : g_sar
            localparam [4:0] DEC = 10 - i;
            localparam [4:0] ARM = 9 - i;
            assign sarNext[i] = (tadCnt_r == DEC) ? compSync2_r :
                                (tadCnt_r == ARM) ? 1'b1 : sar_r[i];
        end
    endgenerate

    // Approximation register, cleared at each conversion start
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            sar_r <= 10'h000;
        end else if (!state_r[5]) begin
            sar_r <= 10'h000;
        end else if (tadTick) begin
            sar_r <= sarNext;
        end
    end

    // Synchronisers for pins, comparator and RC oscillator
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            pinSync1_r  <= 13'h0000;
            pinSync2_r  <= 13'h0000;
            compSync1_r <= 1'b0;
            compSync2_r <= 1'b0;
            rcSync1_r   <= 1'b0;
            rcSync2_r   <= 1'b0;
            rcPrev_r    <= 1'b0;
        end else begin
            pinSync1_r  <= pinLevel;
            pinSync2_r  <= pinSync1_r;
            compSync1_r <= compHighIn;
            compSync2_r <= compSync1_r;
            rcSync1_r   <= rcClkIn;
            rcSync2_r   <= rcSync1_r;
            rcPrev_r    <= rcSync2_r;
        end
    end

    // Analog channel count from the port configuration field
    assign analogCnt = (pcfg_r <= 4'h2) ? 5'd13 : (5'd15 - {1'b0, pcfg_r});

    // Per-pin analog mask and read-back masking
    generate
        for (i = 0; i < 13; i = i + 1) begin : g_pin
            localparam [4:0] IDX = i;
            assign analogPinMask[i] = (IDX < analogCnt);
            assign pinRead[i] = pinSync2_r[i] & ~analogPinMask[i];
        end
    endgenerate

    // Control registers, go flag and strap capture
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            on_r        <= 1'b0;
            go_r        <= 1'b0;
            chan_r      <= 4'h0;
            pcfg_r      <= `PCFG_ALL_ANALOG;
            ref_r       <= 2'h0;
            fmt_r       <= 1'b0;
            acqt_r      <= 3'h0;
            adcs_r      <= 3'h0;
            doneEn_r    <= 1'b0;
            donePri_r   <= 1'b0;
            strapDone_r <= 1'b0;
        end else begin
            // Go: set wins over clear
            go_r <= goSet | (go_r & ~goClr);
            if (wrChan) begin
                on_r   <= regWdata[`F_ON];
                chan_r <= regWdata[`F_CHAN_HI:`F_CHAN_LO];
            end
            // Strap taken on the first edge after reset release
            if (!strapDone_r) begin
                strapDone_r <= 1'b1;
                pcfg_r <= portbAnalogReset ? `PCFG_ALL_ANALOG
                                           : `PCFG_B_DIGITAL;
            end else if (regWr && (regAddr == `RA_CTRL_PORTS)) begin
                pcfg_r <= regWdata[`F_PCFG_HI:`F_PCFG_LO];
                ref_r  <= regWdata[`F_REF_HI:`F_REF_LO];
            end
            if (regWr && (regAddr == `RA_CTRL_TIMING)) begin
                fmt_r  <= regWdata[`F_FMT];
                acqt_r <= regWdata[`F_ACQ_HI:`F_ACQ_LO];
                adcs_r <= regWdata[`F_CLK_HI:`F_CLK_LO];
            end
            if (regWr && (regAddr == `RA_ENABLES)) begin
                doneEn_r <= regWdata[`F_DONE];
            end
            if (regWr && (regAddr == `RA_PRIORITY)) begin
                donePri_r <= regWdata[`F_DONE];
            end
        end
    end

    // Result pair and done flag; hardware completion wins over writes
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            resHigh_r    <= 8'h00;
            resLow_r     <= 8'h00;
            done_r       <= 1'b0;
            timerReset_r <= 1'b0;
        end else begin
            timerReset_r <= trigFire;
            if (convDone) begin
                done_r <= 1'b1;
            end else if (regWr && (regAddr == `RA_FLAGS)) begin
                done_r <= regWdata[`F_DONE];
            end
            // Only a completed conversion or a software write loads the pair
            if (convDone) begin
                if (fmt_r) begin
                    resHigh_r <= {6'h00, sarNext[9:8]};
                    resLow_r  <= sarNext[7:0];
                end else begin
                    resHigh_r <= sarNext[9:2];
                    resLow_r  <= {sarNext[1:0], 6'h00};
                end
            end else begin
                // Aborts fall here and leave the pair alone
                if (regWr && (regAddr == `RA_RES_HIGH)) begin
                    resHigh_r <= regWdata;
                end
                if (regWr && (regAddr == `RA_RES_LOW)) begin
                    resLow_r <= regWdata;
                end
            end
        end
    end

    // Read port: data valid only in the cycle after the strobe
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            regRdata <= 8'h00;
        end else if (!regRd) begin
            regRdata <= 8'h00;
        end else if (regAddr == `RA_RES_HIGH) begin
            regRdata <= resHigh_r;
        end else if (regAddr == `RA_RES_LOW) begin
            regRdata <= resLow_r;
        end else if (regAddr == `RA_CTRL_CHAN) begin
            regRdata <= {2'b00, chan_r, go_r, on_r};
        end else if (regAddr == `RA_CTRL_PORTS) begin
            regRdata <= {2'b00, ref_r, pcfg_r};
        end else if (regAddr == `RA_CTRL_TIMING) begin
            regRdata <= {fmt_r, 1'b0, acqt_r, adcs_r};
        end else if (regAddr == `RA_FLAGS) begin
            regRdata <= {1'b0, done_r, 6'h00};
        end else if (regAddr == `RA_ENABLES) begin
            regRdata <= {1'b0, doneEn_r, 6'h00};
        end else if (regAddr == `RA_PRIORITY) begin
            regRdata <= {1'b0, donePri_r, 6'h00};
        end else if (regAddr == `RA_PIN_LOW) begin
            regRdata <= pinRead[7:0];
        end else if (regAddr == `RA_PIN_HIGH) begin
            regRdata <= {3'b000, pinRead[12:8]};
        end else begin
            regRdata <= 8'h00;
        end
    end

endmodule // adc_conversion_sequencer

// ===== verif/adc_seq_props.sv
// Concurrent checks on the sequencer's ports
`timescale 1ns/1ps
module adc_seq_props (
    input wire        clk,             // System clock
    input wire        reset,           // Async reset
    input wire [3:0]  regAddr,         // Register address
    input wire [7:0]  regWdata,        // Write data
    input wire        regWr,           // Write strobe
    input wire        regRd,           // Read strobe
    input wire [7:0]  regRdata,        // Read data
    input wire        specialTrigger,  // Compare event
    input wire [3:0]  compareTwoMode,  // Compare mode
    input wire        timerReset,      // Timer clear
    input wire        sampleEnable,    // Sampling
    input wire        dischargeEnable, // Discharge
    input wire        convertActive,   // Converting
    input wire [12:0] analogPinMask    // Analog pins
);
    reg  [6:0]  tadClk_r;  // Shadow bit period in clocks, 0 for RC
    reg         acqZero_r; // Shadow of manual acquisition
    reg  [10:0] convCnt_r; // Cycles spent converting
    reg         kill_r, off_r; // Control written, converter off, in a conversion
    wire        trig = specialTrigger && compareTwoMode == 4'hB; // Qualified trigger
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // Shadows the timing field and measures each conversion
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            tadClk_r <= 7'h02;
            acqZero_r <= 1'b1;
            convCnt_r <= 11'h000;
            kill_r <= 1'b0;
            off_r <= 1'b0;
        end else begin
            if (regWr && regAddr == 4'h4) begin
                acqZero_r <= regWdata[5:3] == 3'h0;
                tadClk_r <= regWdata[1:0] == 2'h3 ? 7'h00 : 7'h02 << {regWdata[1:0], regWdata[2]};
            end
            convCnt_r <= convertActive ? convCnt_r + 11'h001 : 11'h000;
            if (sampleEnable) begin
                kill_r <= 1'b0;
                off_r <= 1'b0;
            end else if (regWr && regAddr == 4'h2 && convertActive) begin
                kill_r <= 1'b1;
                off_r <= off_r | !regWdata[0];
            end
        end
    end
    a_timer_clear: assert property (trig |=> timerReset)
        else $error("timer clear missing after trigger");
    a_timer_cause: assert property (timerReset |-> $past(trig))
        else $error("timer clear without trigger");
    a_pin_low: assert property (regRd && regAddr == 4'h8 |=> (regRdata & analogPinMask[7:0]) == 8'h00)
        else $error("analog pin reads high in low byte");
    a_pin_high: assert property (regRd && regAddr == 4'h9 |=> (regRdata[4:0] & analogPinMask[12:8]) == 5'h00)
        else $error("analog pin reads high in high byte");
    a_phase_excl: assert property ($onehot0({sampleEnable, dischargeEnable, convertActive}))
        else $error("two phases active at once");
    a_discharge_first: assert property ($rose(sampleEnable) |-> $past(dischargeEnable))
        else $error("sampling began without discharge");
    a_wait_after: assert property ($fell(convertActive) && !off_r |-> dischargeEnable)
        else $error("no wait after conversion");
    a_conv_exact: assert property ($fell(convertActive) && !kill_r && tadClk_r != 7'h00
        |-> convCnt_r == 11 * tadClk_r)
        else $error("conversion length wrong");
    a_start_delay: assert property ($fell(sampleEnable) && acqZero_r |-> !convertActive [*4])
        else $error("manual conversion started early");
    c_done: cover property ($fell(convertActive) && !kill_r);
    c_abort: cover property ($fell(convertActive) && kill_r);
    c_trig: cover property (trig);
endmodule // adc_seq_props
bind adc_conversion_sequencer adc_seq_props u_props (.clk(clk), .reset(reset), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .specialTrigger(specialTrigger), .compareTwoMode(compareTwoMode), .timerReset(timerReset),
    .sampleEnable(sampleEnable), .dischargeEnable(dischargeEnable),
    .convertActive(convertActive), .analogPinMask(analogPinMask));

// ===== verif/adc_front_model.sv
// Analog front end: holding capacitor, comparator and RC oscillator
`timescale 1ns/1ps
module adc_front_model (
    input  wire       clk,          // System clock
    input  wire       sampleEnable, // Sampling switch closed
    input  wire [9:0] levelIn,      // Level of the selected channel
    input  wire [9:0] dacCode,      // Trial code
    output wire       compHighIn,   // Held level at or above code
    output reg        rcClkIn       // Free-running RC oscillator
);
    reg [9:0] held_r = 10'h000; // Level on the holding capacitor
    initial rcClkIn = 1'b0;
    // Oscillator runs free, unrelated in phase to clk
    always #23.3 rcClkIn = ~rcClkIn;
    // Capacitor follows the input only while sampling
    always @(posedge clk) begin
        if (sampleEnable) begin
            held_r <= levelIn;
        end
    end
    // Level sits half a step above its code, so a tie reads high
    assign compHighIn = held_r >= dacCode;
endmodule // adc_front_model

// ===== verif/test_adc_conversion_sequencer.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module test_adc_conversion_sequencer;
    reg         clk = 1'b0, reset = 1'b1, regWr = 1'b0, regRd = 1'b0; // Clock, reset, strobes
    reg  [3:0]  regAddr = 4'h0, compareTwoMode = 4'h0;  // Address, compare mode
    reg  [7:0]  regWdata = 8'h00, d, lo;                 // Write data, read values
    reg         strap = 1'b1, specialTrigger = 1'b0;     // Reset strap, event
    reg  [12:0] pinLevel = 13'h0000, m;                  // Pin levels, mask
    reg  [9:0]  level = 10'h000;                         // Analog input level
    reg  [31:0] lfsr = 32'd74009;                        // Random state
    wire [7:0]  regRdata;                                // Read data
    wire [9:0]  dacCode;                                 // Trial code
    wire [12:0] analogPinMask;                           // Analog pins
    wire        compHighIn, rcClkIn, timerReset, sampleEnable, dischargeEnable, convertActive;
    integer     n_fail = 0, check_count = 0, cyc = 0, i, t; // Counters
    adc_conversion_sequencer i_dut (.clk(clk), .reset(reset), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .portbAnalogReset(strap), .pinLevel(pinLevel), .compHighIn(compHighIn),
        .rcClkIn(rcClkIn), .specialTrigger(specialTrigger), .compareTwoMode(compareTwoMode),
        .timerReset(timerReset), .sampleEnable(sampleEnable), .dischargeEnable(dischargeEnable),
        .convertActive(convertActive), .dacCode(dacCode), .channelSelect(),
        .referenceConfig(), .analogPinMask(analogPinMask));
    adc_front_model i_front (.clk(clk), .sampleEnable(sampleEnable), .levelIn(level),
        .dacCode(dacCode), .compHighIn(compHighIn), .rcClkIn(rcClkIn));
    always #2.5 clk = ~clk;
    // Cuts a hang short
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            close_out;
        end
    end
    function [31:0] rnd(input [31:0] s);
        rnd = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Pins analog under a port configuration code
    function [12:0] amask(input [3:0] p);
        integer k;
        for (k = 0; k < 13; k = k + 1) amask[k] = k < (p <= 4'h2 ? 13 : 15 - p);
    endfunction
    function sig(input integer s);
        sig = s == 0 ? convertActive : s == 1 ? dischargeEnable : sampleEnable;
    endfunction
    task chk(input string nm, input [15:0] e, input [15:0] g);
        check_count = check_count + 1;
        if (g !== e) begin
            n_fail = n_fail + 1;
            $display("Error %0s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input [3:0] a, input [7:0] v);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= v;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task rd(input [3:0] a, output [7:0] v);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 v = regRdata;
    endtask
    // Counts cycles until a phase reaches a level, bounded
    task till(input integer s, input v);
        #1 t = 0;
        while (sig(s) !== v && t < 3000) begin
            @(posedge clk);
            #1 t = t + 1;
        end
        chk("wait", 16'h0001, t < 3000);
    endtask
    task trig(input [3:0] mo);
        @(posedge clk);
        compareTwoMode <= mo;
        specialTrigger <= 1'b1;
        @(posedge clk);
        specialTrigger <= 1'b0;
        #1 chk("timerReset", mo == 4'hB, timerReset);
    endtask
    // One full conversion; timing checked unless the RC clock sets it
    task conv(input [2:0] acq, input [2:0] adcs, input fmt);
        integer ta, dv;
        reg [3:0] ch;
        dv = 2 << {adcs[1:0], adcs[2]};
        ta = acq == 3'h0 ? 4 : dv * (acq < 3'h5 ? 2 * acq : 4 * (acq - 2));
        {level, ch} = lfsr[13:0];
        lfsr = rnd(lfsr);
        wr(4'h4, {fmt, 1'b0, acq, adcs});
        wr(4'h2, {2'h0, ch, 2'h1});
        till(2, 1);
        wr(4'h2, {2'h0, ch, 2'h3});
        till(0, 1);
        if (dv < 128) chk("start", 16'h0001, t >= ta && t <= ta + 3);
        till(0, 0);
        if (dv < 128) chk("convLen", 11 * dv, t);
        till(1, 0);
        if (dv < 128) chk("discharge", 2 * dv, t);
        chk("resample", 16'h0001, sampleEnable);
        rd(4'h5, d);
        chk("done", 16'h0001, d[6]);
        rd(4'h2, d);
        chk("ctrl", {ch, ch, 2'h1}, {i_dut.channelSelect, d[5:0]});
        rd(4'h0, d);
        rd(4'h1, lo);
        chk("result", fmt ? {6'h00, level} : {level, 6'h00}, {d, lo});
        wr(4'h5, 8'h00);
    endtask
    task close_out;
        $display("Checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        rd(4'h3, d);
        chk("pcfg", 16'h0000, d);
        rd(4'hF, d);
        chk("unmapped", 16'h0000, d);
        // Every port configuration against random pin levels
        for (i = 0; i < 16; i = i + 1) begin
            @(posedge clk);
            pinLevel <= lfsr[12:0];
            lfsr = rnd(lfsr);
            wr(4'h3, {2'h0, i[1:0], i[3:0]});
            m = amask(i[3:0]);
            rd(4'h8, d);
            chk("pinsLow", pinLevel[7:0] & ~m[7:0], d);
            rd(4'h9, d);
            chk("pinsHigh", pinLevel[12:8] & ~m[12:8], d);
            chk("mask", {i[1:0], m}, {i_dut.referenceConfig, analogPinMask});
        end
        for (i = 0; i < 8; i = i + 1)
            conv(i[2:0], {i[0] | i[2:1] == 2'h0, i[2:1] == 2'h3 ? 2'h1 : i[2:1]}, i[0]);
        conv(3'h0, 3'h3, 1'b1);
        // Abort mid-conversion after software wrote the result pair
        wr(4'h4, 8'h80);
        wr(4'h0, 8'h5A);
        wr(4'h1, 8'hC3);
        wr(4'h2, 8'h03);
        till(0, 1);
        repeat (5) @(posedge clk);
        wr(4'h2, 8'h01);
        till(0, 0);
        chk("abort", 16'h0001, t <= 2);
        till(1, 0);
        chk("abortWait", 16'd4, t);
        rd(4'h0, d);
        rd(4'h1, lo);
        chk("kept", 16'h5AC3, {d, lo});
        // Hardware start, other mode, then converter off
        trig(4'hB);
        till(0, 1);
        till(0, 0);
        rd(4'h5, d);
        chk("hwDone", 16'h0001, d[6]);
        trig(4'h2);
        wr(4'h2, 8'h00);
        trig(4'hB);
        repeat (20) @(posedge clk);
        rd(4'h2, d);
        chk("ignored", 16'h0000, {d[1], convertActive});
        // Second reset with port B digital
        strap <= 1'b0;
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        rd(4'h3, d);
        chk("pcfgDigital", 16'h0007, d);
        close_out;
    end
endmodule // test_adc_conversion_sequencer
